// *** rmec_core.sv ***
// Purpose: banked registers, status word, conditions and exception entry
// Assumes: one instruction presented per cycle at its commit point
// Notes: all inputs synchronous to clk
`timescale 1ns/1ps
`default_nettype none
// Function
// - 27 physical registers, 16 visible per mode
// - mode from status word low two bits
// - fast mode banks r8-r14, link holds restart
// - interrupt mode banks r13 and r14
// - supervisor mode banks r13 and r14
// - r15 shared: flags, 24-bit pc, mode
// - branch-with-link writes current mode link
// - translate in user mode or forced
// - user writes to privileged bits ignored
// - 16 conditions, always and never codes
// - unsigned and flag condition codes 0-9
// - signed condition codes A-D
// - interrupt entry within latency bound
// - data address above 26 bits traps
// - pc wraps to zero without trap
// - aborted single transfer fully cancelled
// - aborted multi transfer runs to completion
// - aborted multi still writes back base
// - software trap saves r15, enters supervisor
// - undefined instruction uses its own vector
// - reset: supervisor, both masked, address zero
// - dummy fetches while reset held
// - fixed priority among simultaneous exceptions
// - supervisor entry masks irq, keeps fiq
// - fast interrupt vector is last slot
module rmec_core (
  input wire logic clk,
  input wire logic rst,
  input wire rmec_pkg::rmec_instr_s instr,
  input wire rmec_pkg::rmec_wr_s reg_wr,
  input wire rmec_pkg::rmec_wr_s base_wr,
  input wire rmec_pkg::rmec_wr_s status_wr,
  input wire logic [3:0] rd_sel,
  input wire logic data_valid,
  input wire logic [31:0] data_addr,
  input wire logic data_abort,
  input wire logic force_translate,
  input wire logic fast_interrupt,
  input wire logic normal_interrupt,
  output logic [31:0] rd_data_q,
  output logic [31:0] status_word,
  output logic [25:0] fetch_addr,
  output logic translate_n,
  output logic cond_pass,
  output logic dummy_fetch_q,
  output logic exc_taken_q,
  output logic [23:0] exc_vector_q
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // banked index for a visible register in a mode
  function automatic logic [4:0] phys_idx(input logic [1:0] m, input logic [3:0] r);
    logic [4:0] res;
    res = {1'b0, r};
    if (m == rmec_pkg::MODE_FIQ && r >= rmec_pkg::REG_FIQ_LO)
      res = 5'(rmec_pkg::BASE_FIQ + {1'b0, r} - {1'b0, rmec_pkg::REG_FIQ_LO});
    else if (m == rmec_pkg::MODE_IRQ && r >= rmec_pkg::REG_STACK)
      res = 5'(rmec_pkg::BASE_IRQ + {1'b0, r} - {1'b0, rmec_pkg::REG_STACK});
    else if (m == rmec_pkg::MODE_SVC && r >= rmec_pkg::REG_STACK)
      res = 5'(rmec_pkg::BASE_SVC + {1'b0, r} - {1'b0, rmec_pkg::REG_STACK});
    return res;
  endfunction

  function automatic logic cond_eval(input logic [3:0] c, input logic [31:0] s);
    logic n;
    logic z;
    logic cy;
    logic v;
    logic res;
    n = s[rmec_pkg::FLAG_N];
    z = s[rmec_pkg::FLAG_Z];
    cy = s[rmec_pkg::FLAG_C];
    v = s[rmec_pkg::FLAG_V];
    case (c)
      rmec_pkg::COND_EQ: res = z;
      rmec_pkg::COND_NE: res = !z;
      rmec_pkg::COND_CS: res = cy;
      rmec_pkg::COND_CC: res = !cy;
      rmec_pkg::COND_MI: res = n;
      rmec_pkg::COND_POS: res = !n;
      rmec_pkg::COND_OVS: res = v;
      rmec_pkg::COND_OVC: res = !v;
      rmec_pkg::COND_HIGH: res = cy && !z;
      rmec_pkg::COND_LOWS: res = !cy || z;
      rmec_pkg::COND_GEQ: res = (n == v);
      rmec_pkg::COND_LESS: res = (n != v);
      rmec_pkg::COND_GRT: res = (n == v) && !z;
      rmec_pkg::COND_LEQ: res = (n != v) || z;
      rmec_pkg::COND_ALWAYS: res = 1'b1;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  // banked storage
  logic [31:0] bank_q [rmec_pkg::NUM_BANKED];
  logic [31:0] status_q;
  logic [31:0] status_d;
  wire [1:0] mode = status_q[rmec_pkg::MODE_HI:rmec_pkg::MODE_LO];
  wire [23:0] pc = status_q[rmec_pkg::PC_HI:rmec_pkg::PC_LO];
  wire [23:0] pc_next = pc + rmec_pkg::PC_STEP;
  wire [31:0] link_value = {status_q[31:26], pc_next, mode};
  wire is_user = (mode == rmec_pkg::MODE_USER);

  // ----------------------------------------
  // condition evaluation
  // ----------------------------------------
  // cond decode
  assign cond_pass = cond_eval(instr.cond, status_q);

  // ----------------------------------------
  // exception detection and priority
  // ----------------------------------------
  // out of range data
  wire exc_addr = data_valid && instr.valid && (|data_addr[31:rmec_pkg::ADDR_BITS]);
  wire exc_dabort = data_valid && instr.valid && data_abort;
  wire exc_fiq = fast_interrupt && !status_q[rmec_pkg::MASK_F];
  wire exc_irq = normal_interrupt && !status_q[rmec_pkg::MASK_I];
  wire exc_pabort = instr.valid && instr.prefetch_abort;
  wire exc_undef = instr.valid && cond_pass && (instr.kind == rmec_pkg::RMEC_K_UNDEFINED);
  wire exc_swtrap = instr.valid && cond_pass && (instr.kind == rmec_pkg::RMEC_K_SOFTWARE_TRAP);
  logic exc_any;
  logic exc_set_f;
  logic [1:0] exc_mode;
  logic [23:0] exc_vec;

  always_comb
  begin
    exc_any = 1'b1;
    exc_set_f = 1'b0;
    exc_mode = rmec_pkg::MODE_SVC;
    exc_vec = rmec_pkg::VEC_SWTRAP;
    if (exc_addr)
      exc_vec = rmec_pkg::VEC_ADDREXC;
    else if (exc_dabort)
      exc_vec = rmec_pkg::VEC_DABORT;
    else if (exc_fiq)
    begin
      exc_vec = rmec_pkg::VEC_FIQ;
      exc_mode = rmec_pkg::MODE_FIQ;
      exc_set_f = 1'b1;
    end
    else if (exc_irq)
    begin
      exc_vec = rmec_pkg::VEC_IRQ;
      exc_mode = rmec_pkg::MODE_IRQ;
    end
    else if (exc_pabort)
      exc_vec = rmec_pkg::VEC_PABORT;
    else if (exc_undef)
      exc_vec = rmec_pkg::VEC_UNDEF;
    else if (exc_swtrap)
      exc_vec = rmec_pkg::VEC_SWTRAP;
    else
      exc_any = 1'b0;
  end

  // ----------------------------------------
  // commit qualification
  // ----------------------------------------
  // skip on false condition
  wire commit = instr.valid && cond_pass && !exc_any;
  wire multi_abort = !exc_addr && exc_dabort && cond_pass && (instr.kind == rmec_pkg::RMEC_K_MULTI_XFER);
  wire wr_ok = commit || multi_abort;
  wire is_branch = (instr.kind == rmec_pkg::RMEC_K_BRANCH) || (instr.kind == rmec_pkg::RMEC_K_BRANCH_LINK);
  wire link_commit = commit && (instr.kind == rmec_pkg::RMEC_K_BRANCH_LINK);
  wire [4:0] wr_idx = phys_idx(mode, reg_wr.sel);
  wire [4:0] base_idx = phys_idx(mode, base_wr.sel);
  wire [4:0] link_cur_idx = phys_idx(mode, rmec_pkg::REG_LINK);
  wire [4:0] link_exc_idx = phys_idx(exc_mode, rmec_pkg::REG_LINK);
  wire [4:0] rd_idx = phys_idx(mode, rd_sel);

  // ----------------------------------------
  // status word next value
  // ----------------------------------------
  always_comb
  begin
    status_d = status_q;
    if (exc_any)
    begin
      status_d[rmec_pkg::MASK_I] = 1'b1;
      if (exc_set_f)
        status_d[rmec_pkg::MASK_F] = 1'b1;
      status_d[rmec_pkg::MODE_HI:rmec_pkg::MODE_LO] = exc_mode;
      status_d[rmec_pkg::PC_HI:rmec_pkg::PC_LO] = exc_vec;
    end
    else if (instr.valid)
    begin
      status_d[rmec_pkg::PC_HI:rmec_pkg::PC_LO] = (commit && is_branch) ? instr.target : pc_next;
      if (commit && status_wr.en)
      begin
        status_d[rmec_pkg::FLAG_N:rmec_pkg::FLAG_V] = status_wr.data[rmec_pkg::FLAG_N:rmec_pkg::FLAG_V];
        if (!is_user)
        begin
          status_d[rmec_pkg::MASK_I:rmec_pkg::MASK_F] = status_wr.data[rmec_pkg::MASK_I:rmec_pkg::MASK_F];
          status_d[rmec_pkg::MODE_HI:rmec_pkg::MODE_LO] = status_wr.data[rmec_pkg::MODE_HI:rmec_pkg::MODE_LO];
        end
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // single-cycle entry
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_q <= rmec_pkg::STATUS_RESET;
      dummy_fetch_q <= 1'b1;
      exc_taken_q <= 1'b0;
      exc_vector_q <= rmec_pkg::VEC_RESET;
    end
    else
    begin
      status_q <= status_d;
      dummy_fetch_q <= 1'b0;
      exc_taken_q <= exc_any;
      exc_vector_q <= exc_any ? exc_vec : exc_vector_q;
    end
  end

  // ----------------------------------------
  // banked register writes
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst)
    begin
      if (wr_ok && reg_wr.en && reg_wr.sel != rmec_pkg::REG_PC)
        bank_q[wr_idx] <= reg_wr.data;
      if (wr_ok && instr.writeback && base_wr.en && base_wr.sel != rmec_pkg::REG_PC)
        bank_q[base_idx] <= base_wr.data;
      if (link_commit)
        bank_q[link_cur_idx] <= link_value;
      if (exc_any)
        bank_q[link_exc_idx] <= status_q;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // r15 reads status word
  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data_q <= 32'h00000000;
    else
      rd_data_q <= (rd_sel == rmec_pkg::REG_PC) ? status_q : bank_q[rd_idx];
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign status_word = status_q;
  assign fetch_addr = {pc, 2'b00};
  assign translate_n = !(is_user || force_translate);
endmodule
`default_nettype wire

// *** rmec_pkg.sv ***
// Purpose: shared constants and types for the mode and exception control core
// Assumes: 40 MHz clock, synchronous active-high reset
// Notes: mode codes and register index layout are local choices
package rmec_pkg;
  // ----------------------------------------
  // register file sizing
  // ----------------------------------------
  localparam int NUM_PHYS = 27;
  localparam int NUM_VIS = 16;
  localparam int NUM_BANKED = 26;
  localparam logic [3:0] REG_PC = 4'hF;
  localparam logic [3:0] REG_LINK = 4'hE;
  localparam logic [3:0] REG_STACK = 4'hD;
  localparam logic [3:0] REG_FIQ_LO = 4'h8;
  localparam logic [4:0] BASE_FIQ = 5'h0F;
  localparam logic [4:0] BASE_IRQ = 5'h16;
  localparam logic [4:0] BASE_SVC = 5'h18;
  // ----------------------------------------
  // status word layout
  // ----------------------------------------
  localparam int FLAG_N = 31;
  localparam int FLAG_Z = 30;
  localparam int FLAG_C = 29;
  localparam int FLAG_V = 28;
  localparam int MASK_I = 27;
  localparam int MASK_F = 26;
  localparam int PC_HI = 25;
  localparam int PC_LO = 2;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;
  localparam logic [1:0] MODE_USER = 2'h0;
  localparam logic [1:0] MODE_FIQ = 2'h1;
  localparam logic [1:0] MODE_IRQ = 2'h2;
  localparam logic [1:0] MODE_SVC = 2'h3;
  localparam logic [31:0] STATUS_RESET = 32'h0C000003;
  // ----------------------------------------
  // address space and vectors (word addresses)
  // ----------------------------------------
  localparam int ADDR_BITS = 26;
  localparam logic [23:0] VEC_RESET = 24'h000000;
  localparam logic [23:0] VEC_UNDEF = 24'h000001;
  localparam logic [23:0] VEC_SWTRAP = 24'h000002;
  localparam logic [23:0] VEC_PABORT = 24'h000003;
  localparam logic [23:0] VEC_DABORT = 24'h000004;
  localparam logic [23:0] VEC_ADDREXC = 24'h000005;
  localparam logic [23:0] VEC_IRQ = 24'h000006;
  localparam logic [23:0] VEC_FIQ = 24'h000007;
  localparam logic [23:0] PC_STEP = 24'h000001;
  // ----------------------------------------
  // condition codes
  // ----------------------------------------
  localparam logic [3:0] COND_EQ = 4'h0;
  localparam logic [3:0] COND_NE = 4'h1;
  localparam logic [3:0] COND_CS = 4'h2;
  localparam logic [3:0] COND_CC = 4'h3;
  localparam logic [3:0] COND_MI = 4'h4;
  localparam logic [3:0] COND_POS = 4'h5;
  localparam logic [3:0] COND_OVS = 4'h6;
  localparam logic [3:0] COND_OVC = 4'h7;
  localparam logic [3:0] COND_HIGH = 4'h8;
  localparam logic [3:0] COND_LOWS = 4'h9;
  localparam logic [3:0] COND_GEQ = 4'hA;
  localparam logic [3:0] COND_LESS = 4'hB;
  localparam logic [3:0] COND_GRT = 4'hC;
  localparam logic [3:0] COND_LEQ = 4'hD;
  localparam logic [3:0] COND_ALWAYS = 4'hE;
  // ----------------------------------------
  // timing: worst interrupt latency in half clocks
  // ----------------------------------------
  localparam int INSTR_MAX_CLK = 18;
  localparam int LATENCY_HALF_CLK = 45;
  localparam int ENTRY_CYCLES = 1;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    RMEC_K_PLAIN,
    RMEC_K_SINGLE_XFER,
    RMEC_K_MULTI_XFER,
    RMEC_K_BRANCH,
    RMEC_K_BRANCH_LINK,
    RMEC_K_SOFTWARE_TRAP,
    RMEC_K_UNDEFINED
  } rmec_kind_e;
  typedef struct packed {
    logic valid;
    logic [3:0] cond;
    rmec_kind_e kind;
    logic prefetch_abort;
    logic writeback;
    logic [23:0] target;
  } rmec_instr_s;
  typedef struct packed {
    logic en;
    logic [3:0] sel;
    logic [31:0] data;
  } rmec_wr_s;
endpackage

// *** rmec_mmu_model.sv ***
// Purpose: behavioural memory manager answering data accesses
// Assumes: accesses qualified by data_valid
// Notes: faults only while the bench sets fault_en
`timescale 1ns/1ps
`default_nettype none
module rmec_mmu_model (
  input wire logic data_valid,
  input wire logic fault_en,
  output logic data_abort
);
  // ----------------------------------------
  // abort response
  // ----------------------------------------
  // abort during access
  assign data_abort = data_valid && fault_en;
endmodule
`default_nettype wire

// *** rmec_core_props.sv ***
// Purpose: port assertions for the mode and exception core
// Assumes: clk rising edge, rst synchronous active high
// Notes: attached by bind below
`timescale 1ns/1ps
`default_nettype none
module rmec_core_chk (
  input wire logic clk,
  input wire logic rst,
  input wire rmec_pkg::rmec_instr_s instr,
  input wire rmec_pkg::rmec_wr_s status_wr,
  input wire logic data_valid,
  input wire logic [31:0] data_addr,
  input wire logic force_translate,
  input wire logic fast_interrupt,
  input wire logic normal_interrupt,
  input wire logic [31:0] status_word,
  input wire logic [25:0] fetch_addr,
  input wire logic translate_n,
  input wire logic cond_pass,
  input wire logic dummy_fetch_q,
  input wire logic exc_taken_q,
  input wire logic [23:0] exc_vector_q
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire [1:0] mode = status_word[1:0];
  wire quiet = !data_valid && !instr.prefetch_abort && !fast_interrupt && !normal_interrupt;
  AST_RESET: assert property (disable iff (1'b0) rst |=> status_word == 32'h0C000003 && exc_vector_q == 24'h0)
    else $error("reset state wrong");
  AST_DUMMY: assert property (disable iff (1'b0) rst |=> dummy_fetch_q)
    else $error("dummy fetch wrong");
  AST_DUMMYOFF: assert property (disable iff (1'b0) !rst |=> !dummy_fetch_q)
    else $error("dummy fetch after release wrong");
  AST_TRAN: assert property (translate_n == !(mode == rmec_pkg::MODE_USER || force_translate))
    else $error("translate wrong");
  AST_FETCH: assert property (fetch_addr == {status_word[25:2], 2'b00})
    else $error("fetch address wrong");
  AST_NEVER: assert property (instr.cond == 4'hF |-> !cond_pass)
    else $error("never code passed");
  AST_HIGHER: assert property (instr.cond == 4'h8 |-> cond_pass == (status_word[29] && !status_word[30]))
    else $error("higher code wrong");
  AST_SIGNED: assert property (instr.cond == 4'hA |-> cond_pass == (status_word[31] == status_word[28]))
    else $error("signed code wrong");
  AST_SWTRAP: assert property (instr.valid && instr.kind == rmec_pkg::RMEC_K_SOFTWARE_TRAP && cond_pass && quiet
    |=> mode == rmec_pkg::MODE_SVC && status_word[25:2] == 24'h2 && status_word[27] && exc_taken_q
    && status_word[26] == $past(status_word[26])) else $error("software trap entry wrong");
  AST_ADDR: assert property (instr.valid && data_valid && data_addr[31:26] != 6'h0
    |=> exc_taken_q && exc_vector_q == 24'h5 && mode == rmec_pkg::MODE_SVC) else $error("address trap wrong");
  AST_FIQ: assert property (fast_interrupt && !status_word[26] && !data_valid
    |=> mode == rmec_pkg::MODE_FIQ && status_word[25:2] == 24'h7 && status_word[27:26] == 2'b11)
    else $error("fast entry wrong");
  AST_SKIP: assert property (instr.valid && !cond_pass && quiet
    |=> status_word[25:2] == $past(status_word[25:2]) + 24'h1 && !exc_taken_q) else $error("skip wrong");
  AST_USERWR: assert property (mode == rmec_pkg::MODE_USER && status_wr.en && quiet && instr.valid && cond_pass
    && instr.kind == rmec_pkg::RMEC_K_PLAIN
    |=> mode == rmec_pkg::MODE_USER && status_word[27:26] == $past(status_word[27:26])
    && status_word[31:28] == $past(status_wr.data[31:28])) else $error("user status write wrong");
endmodule
bind rmec_core rmec_core_chk u_chk (.clk, .rst, .instr, .status_wr, .data_valid, .data_addr, .force_translate,
  .fast_interrupt, .normal_interrupt, .status_word, .fetch_addr, .translate_n, .cond_pass, .dummy_fetch_q,
  .exc_taken_q, .exc_vector_q);
`default_nettype wire

// *** testbench.sv ***
// Purpose: self-checking bench for the mode and exception core
// Assumes: inputs driven at falling edge
// Notes: reset and translate checks first, then condition table, then hand-written cases
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  rmec_pkg::rmec_instr_s instr = '0;
  rmec_pkg::rmec_wr_s reg_wr = '0;
  rmec_pkg::rmec_wr_s base_wr = '0;
  rmec_pkg::rmec_wr_s status_wr = '0;
  logic [3:0] rd_sel = 4'h0;
  logic data_valid = 1'b0;
  logic [31:0] data_addr = 32'h0;
  logic force_translate = 1'b0;
  logic fast_interrupt = 1'b0;
  logic normal_interrupt = 1'b0;
  logic fault_en = 1'b0;
  logic data_abort;
  logic [31:0] rd_data_q;
  logic [31:0] status_word;
  logic [25:0] fetch_addr;
  logic translate_n, cond_pass, dummy_fetch_q, exc_taken_q;
  logic [23:0] exc_vector_q;
  logic [31:0] old;
  int miscompares = 0;
  int checked = 0;
  // cond, nzcv, expected pass
  logic [11:0] rows [22] = '{12'h041, 12'h140, 12'h221, 12'h320, 12'h481, 12'h580, 12'h611, 12'h710, 12'h821,
    12'h860, 12'h961, 12'h920, 12'hA91, 12'hA80, 12'hB81, 12'hB00, 12'hC91, 12'hCD0, 12'hDD1, 12'hD00, 12'hE01, 12'hFF0};
  always #12.5 clk = ~clk;
  rmec_core dut (.clk, .rst, .instr, .reg_wr, .base_wr, .status_wr, .rd_sel, .data_valid, .data_addr, .data_abort,
    .force_translate, .fast_interrupt, .normal_interrupt, .rd_data_q, .status_word, .fetch_addr, .translate_n,
    .cond_pass, .dummy_fetch_q, .exc_taken_q, .exc_vector_q);
  rmec_mmu_model mmu (.data_valid, .fault_en, .data_abort);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results;
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic op(input rmec_pkg::rmec_kind_e k, input logic [3:0] c, s, input logic [31:0] d, input logic [23:0] t);
    instr = '{1'b1, c, k, 1'b0, instr.writeback, t};
    reg_wr = '{1'b1, s, d};
    @(negedge clk);
    instr.valid = 1'b0;
    reg_wr.en = 1'b0;
    data_valid = 1'b0;
  endtask
  task automatic sw(input logic [31:0] d);
    instr = '{1'b1, 4'hE, rmec_pkg::RMEC_K_PLAIN, 1'b0, instr.writeback, 24'h0};
    status_wr = '{1'b1, 4'h0, d};
    @(negedge clk);
    instr.valid = 1'b0;
    status_wr.en = 1'b0;
  endtask
  task automatic rd(input logic [3:0] s);
    rd_sel = s;
    @(negedge clk);
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    results;
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(negedge clk);
    `CK("reset status", 32'h0C000003, status_word)
    `CK("dummy", 1'b1, dummy_fetch_q)
    `CK("tran svc", 1'b1, translate_n)
    rst = 1'b0;
    force_translate = 1'b1;
    @(negedge clk);
    `CK("dummy off", 1'b0, dummy_fetch_q)
    `CK("tran forced", 1'b0, translate_n)
    force_translate = 1'b0;
    foreach (rows[i])
    begin
      sw({rows[i][7:4], 28'hC000003});
      instr.cond = rows[i][11:8];
      #1;
      `CK("cond_pass", rows[i][0], cond_pass)
    end
    op(rmec_pkg::RMEC_K_PLAIN, 4'hE, 4'hD, 32'h5A5A0013, 24'h0);
    op(rmec_pkg::RMEC_K_PLAIN, 4'hE, 4'h0, 32'h1, 24'h0);
    sw(32'h0);
    `CK("tran user", 1'b0, translate_n)
    op(rmec_pkg::RMEC_K_PLAIN, 4'hE, 4'hD, 32'h0D0D, 24'h0);
    sw(32'hFC000003);
    `CK("user status", 32'hF0000000, status_word & 32'hFC000003)
    old = status_word;
    op(rmec_pkg::RMEC_K_SOFTWARE_TRAP, 4'hE, 4'hF, 32'h0, 24'h0);
    `CK("trap status", {4'hF, 2'b10, 24'h2, 2'b11}, status_word)
    rd(4'hE);
    `CK("svc link", old, rd_data_q)
    rd(4'hD);
    `CK("svc r13", 32'h5A5A0013, rd_data_q)
    sw(32'h0);
    rd(4'hD);
    `CK("user r13", 32'h0D0D, rd_data_q)
    op(rmec_pkg::RMEC_K_UNDEFINED, 4'hE, 4'hF, 32'h0, 24'h0);
    `CK("undef vector", 24'h1, exc_vector_q)
    sw(32'h0);
    old = status_word;
    fast_interrupt = 1'b1;
    normal_interrupt = 1'b1;
    @(negedge clk);
    fast_interrupt = 1'b0;
    normal_interrupt = 1'b0;
    `CK("fiq status", {old[31:28], 2'b11, 24'h7, 2'b01}, status_word)
    rd(4'hE);
    `CK("fiq link", old, rd_data_q)
    sw(32'h0);
    fast_interrupt = 1'b1;
    data_valid = 1'b1;
    data_addr = 32'h04000000;
    op(rmec_pkg::RMEC_K_SINGLE_XFER, 4'hE, 4'hF, 32'h0, 24'h0);
    fast_interrupt = 1'b0;
    `CK("addr vector", 24'h5, exc_vector_q)
    sw(32'h0);
    old = status_word;
    data_valid = 1'b1;
    data_addr = 32'h03FFFFFC;
    op(rmec_pkg::RMEC_K_SINGLE_XFER, 4'hE, 4'hF, 32'h0, 24'h0);
    `CK("in range pc", old[25:2] + 24'h1, status_word[25:2])
    fault_en = 1'b1;
    data_valid = 1'b1;
    data_addr = 32'h0;
    op(rmec_pkg::RMEC_K_SINGLE_XFER, 4'hE, 4'h0, 32'hDEAD, 24'h0);
    `CK("abort vector", 24'h4, exc_vector_q)
    rd(4'h0);
    `CK("cancelled load", 32'h1, rd_data_q)
    sw(32'h0);
    instr.writeback = 1'b1;
    base_wr = '{1'b1, 4'h2, 32'h33};
    data_valid = 1'b1;
    op(rmec_pkg::RMEC_K_MULTI_XFER, 4'hE, 4'h2, 32'h22, 24'h0);
    base_wr.en = 1'b0;
    instr.writeback = 1'b0;
    fault_en = 1'b0;
    `CK("multi vector", 24'h4, exc_vector_q)
    rd(4'h2);
    `CK("base writeback", 32'h33, rd_data_q)
    old = status_word;
    op(rmec_pkg::RMEC_K_BRANCH_LINK, 4'hE, 4'hF, 32'h0, 24'hFFFFFF);
    `CK("branch pc", 24'hFFFFFF, status_word[25:2])
    rd(4'hE);
    `CK("link", {old[31:26], old[25:2] + 24'h1, old[1:0]}, rd_data_q)
    op(rmec_pkg::RMEC_K_PLAIN, 4'hE, 4'hF, 32'h0, 24'h0);
    `CK("pc wrap", 24'h0, status_word[25:2])
    `CK("no trap", 1'b0, exc_taken_q)
    op(rmec_pkg::RMEC_K_PLAIN, 4'hF, 4'h0, 32'h99, 24'h0);
    `CK("skip pc", 24'h1, status_word[25:2])
    rd(4'h0);
    `CK("skip reg", 32'h1, rd_data_q)
    rst = 1'b1;
    @(negedge clk);
    `CK("rereset", 32'h0C000003, status_word)
    `CK("redummy", 1'b1, dummy_fetch_q)
    results;
  end
endmodule
`default_nettype wire
